//--- test/dcsb_core_sva.sv
`timescale 1ns/1ps
// ----
// port checks
// ----
module dcsb_core_sva
  #(
    parameter int STARTUP_CYC = 5000,
    parameter int RETRY_CYC   = 8000
  )
  (
    input wire logic        mclk_i,
    input wire logic        rst_i,
    input wire logic [2:0]  oc_recovery_en_i,
    input wire logic [2:0]  hs_drive_o,
    input wire logic [3:0]  cm_route_o,
    input wire logic [23:0] status_word_o,
    input wire logic        clear_all_status_o,
    input wire logic        active_mode_o
  );
  logic [31:0] nr_cnt;
  logic [31:0] on_run;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // length of the not-ready phase
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      nr_cnt <= '0;
    else
      nr_cnt <= status_word_o[18] ? nr_cnt + 32'h1 : '0;
  // length of an on-run of the tripped eighth output
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      on_run <= '0;
    else
      on_run <= (hs_drive_o[2] && status_word_o[17]) ? on_run + 32'h1 : '0;
  a_retry_window: assert property (
    on_run <= RETRY_CYC * 25 / 100)
    else $error("retry on-window too long");
  a_status_fixed: assert property (
    !$past(rst_i) |-> status_word_o[23] && !status_word_o[16])
    else $error("fixed status bits wrong");
  a_thermal_off: assert property (
    status_word_o[20] |-> hs_drive_o == 3'h0)
    else $error("drive on during thermal flag");
  a_startup_off: assert property (
    status_word_o[18] && !active_mode_o |-> hs_drive_o == 3'h0)
    else $error("drive on before start-up end");
  a_startup_len: assert property (
    $fell(status_word_o[18]) |-> nr_cnt >= STARTUP_CYC - 1 && nr_cnt <= STARTUP_CYC + 2)
    else $error("not-ready length wrong");
  a_ready_active: assert property (
    $fell(status_word_o[18]) |-> active_mode_o)
    else $error("not-ready cleared while inactive");
  a_fault_nor: assert property (
    (|status_word_o[22:1]) |-> !status_word_o[0])
    else $error("no-fault bit set with fault");
  a_monitor_hot: assert property (
    $onehot(cm_route_o))
    else $error("monitor route not one-hot");
  a_clear_pulse: assert property (
    clear_all_status_o |=> !clear_all_status_o)
    else $error("clear pulse too long");
  a_warn_quiet: assert property (
    $rose(status_word_o[19]) |-> $stable(hs_drive_o))
    else $error("warning changed a drive");
  a_oc_off: assert property (
    status_word_o[14] && !oc_recovery_en_i[0] |-> !hs_drive_o[0])
    else $error("tripped output still driven");
endmodule

//--- test/dcsb_host.sv
`timescale 1ns/1ps
// ----
// serial host model
// ----
module dcsb_host
  (
    output logic        link_clk_o,
    output logic [23:0] frame_word_o,
    output logic        frame_commit_o
  );
  initial
  begin
    link_clk_o     = 1'h0;
    frame_word_o   = 24'hA5A5A5;
    frame_commit_o = 1'h0;
  end
  // 24 link clocks a frame, clock still between frames
  task automatic send_word(input logic [23:0] word);
    for (int i = 0; i < 24; i++)
    begin
      #62.5 link_clk_o = 1'h1;
      #62.5 link_clk_o = 1'h0;
      if (i == 22)
      begin
        frame_word_o   = word;
        frame_commit_o = 1'h1;
      end
    end
    // word no longer valid, show its inverse
    frame_commit_o = 1'h0;
    frame_word_o   = ~word;
  endtask
endmodule

//--- test/driver_control_status_bits_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
// ----
// bench top
// ----
module driver_control_status_bits_test;
  import dcsb_pkg::*;
  localparam int         SU  = 20;
  localparam int         RT  = 100;
  localparam dcsb_word_t ON  = 24'h82C000;
  localparam dcsb_word_t CLR = 24'h400000;
  typedef struct {dcsb_word_t w; logic [2:0] hs; logic [3:0] cm;} dcsb_row_s;
  dcsb_row_s   rows [5];
  logic        mclk_i = 1'h0, rst_i = 1'h1, link_clk, commit, ffree, clr_all, active;
  logic        vs_over = 1'h0, vs_under = 1'h0, therm = 1'h0, warn = 1'h0, other = 1'h0;
  logic [2:0]  oc = 3'h0, oc_rec = 3'h0, hs;
  logic [12:0] lower = 13'h0000;
  logic [3:0]  cm;
  dcsb_word_t  fword, status;
  int          err_total = 0, tests_run = 0, cyc = 0, cnt, clr_cnt = 0;

  always #10 mclk_i = ~mclk_i;

  // one-cycle clear pulses, seen once each at the settled edge
  always @(negedge mclk_i) clr_cnt += int'(clr_all === 1'h1);

  dcsb_core #(.STARTUP_CYC(SU), .RETRY_CYC(RT)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .link_clk_i(link_clk), .frame_word_i(fword),
    .frame_commit_i(commit), .vs_over_i(vs_over), .vs_under_i(vs_under),
    .thermal_shutdown_i(therm), .temp_warning_i(warn), .overcurrent_i(oc),
    .oc_recovery_en_i(oc_rec), .lower_status_i(lower), .other_word_fault_i(other),
    .hs_drive_o(hs), .cm_route_o(cm), .status_word_o(status), .fault_free_o(ffree),
    .clear_all_status_o(clr_all), .active_mode_o(active));
  dcsb_host host (.link_clk_o(link_clk), .frame_word_o(fword), .frame_commit_o(commit));

  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  task automatic send(input dcsb_word_t w);
    host.send_word(w);
    wait_cyc(10);
  endtask

  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      wrap_up();
    end
  end

  initial
  begin
    rows[0] = '{24'h804000, 3'h1, 4'h1};
    rows[1] = '{24'h848000, 3'h2, 4'h2};
    rows[2] = '{24'h8B0000, 3'h4, 4'h4};
    rows[3] = '{24'h8EC000, 3'h7, 4'h8};
    rows[4] = '{24'h000001, 3'h7, 4'h8};
    wait_cyc(6);
    rst_i = 1'h0;
    wait_cyc(2);
    send(ON);
    `CHK("not_ready", 1'h1, status[18])
    `CHK("startup_drive", 3'h0, hs)
    cnt = 0;
    while (status[18] !== 1'h0 && cnt < 60)
    begin
      wait_cyc(1);
      cnt++;
    end
    `CHK("not_ready_end", 1'h0, status[18])
    `CHK("ready_drive", 3'h7, hs)
    `CHK("ready_active", 1'h1, active)
    foreach (rows[i])
    begin
      send(rows[i].w);
      `CHK("drive", rows[i].hs, hs)
      `CHK("monitor", rows[i].cm, cm)
      `CHK("zero_bit", 1'h0, status[16])
    end
    // thermal shutdown held until the reset bit
    therm = 1'h1;
    wait_cyc(6);
    therm = 1'h0;
    wait_cyc(8);
    `CHK("thermal_flag", 1'h1, status[20])
    `CHK("thermal_drive", 3'h0, hs)
    wait_cyc(20);
    `CHK("thermal_hold", 3'h0, hs)
    send(ON | CLR);
    `CHK("thermal_clr", 1'h0, status[20])
    `CHK("thermal_back", 3'h7, hs)
    warn = 1'h1;
    wait_cyc(10);
    `CHK("warn_flag", 1'h1, status[19])
    `CHK("warn_drive", 3'h7, hs)
    `CHK("warn_nor", 1'h0, ffree)
    warn = 1'h0;
    send(ON | CLR);
    `CHK("nor_clear", 1'h1, ffree)
    other = 1'h1;
    lower = 13'h1555;
    wait_cyc(4);
    `CHK("lower_copy", 13'h1555, status[13:1])
    `CHK("other_nor", 1'h0, ffree)
    other = 1'h0;
    lower = 13'h0000;
    // supply fault recovers by itself
    vs_under = 1'h1;
    wait_cyc(10);
    `CHK("under_flag", 1'h1, status[21])
    `CHK("under_drive", 3'h0, hs)
    vs_under = 1'h0;
    wait_cyc(10);
    `CHK("under_back", 3'h7, hs)
    vs_over = 1'h1;
    therm = 1'h1;
    wait_cyc(10);
    vs_over = 1'h0;
    therm = 1'h0;
    wait_cyc(10);
    `CHK("over_thermal", 3'h0, hs)
    send(ON | CLR);
    oc = 3'h1;
    wait_cyc(8);
    oc = 3'h0;
    wait_cyc(8);
    `CHK("oc_flag", 1'h1, status[14])
    `CHK("oc_drive", 3'h6, hs)
    send(ON | CLR);
    `CHK("oc_back", 3'h7, hs)
    oc_rec = 3'h4;
    oc = 3'h4;
    for (int d = 0; d < 2; d++)
    begin
      send(ON | (dcsb_word_t'(d) << 21));
      wait_cyc(20);
      cnt = 0;
      repeat (RT)
      begin
        wait_cyc(1);
        cnt += int'(hs[2] === 1'h1);
      end
      `CHK("duty", (d == 1) ? RT * 25 / 100 : RT * 12 / 100, cnt)
    end
    oc = 3'h0;
    oc_rec = 3'h0;
    send(24'h000000);
    `CHK("clear_pulses", 4, clr_cnt)
    `CHK("standby", 1'h0, active)
    `CHK("standby_drive", 3'h0, hs)
    rst_i = 1'h1;
    wait_cyc(2);
    `CHK("rst_status", 24'h000000, status)
    `CHK("rst_monitor", 4'h1, cm)
    rst_i = 1'h0;
    wait_cyc(4);
    wrap_up();
  end
endmodule

bind dcsb_core dcsb_core_sva #(.STARTUP_CYC(STARTUP_CYC), .RETRY_CYC(RETRY_CYC)) u_sva (
  .mclk_i(mclk_i), .rst_i(rst_i), .oc_recovery_en_i(oc_recovery_en_i),
  .hs_drive_o(hs_drive_o), .cm_route_o(cm_route_o), .status_word_o(status_word_o),
  .clear_all_status_o(clear_all_status_o), .active_mode_o(active_mode_o));

//--- verilog/dcsb_core.sv
// Function
// - outputs return by themselves when supply is normal again, only if thermal flag clear
// - thermal shutdown sets status bit 20 and switches every output off
// - outputs stay off until host reset bit clears thermal flag
// - temperature warning sets status bit 19 and changes no output
// - standby to active sets status bit 18, starts timer, outputs held off
// - not-ready bit clears by itself when the start-up timer expires
// - with recovery on, tripped output retries at 12% or 25% duty by bit 21
// - over-current sets output flag, disables driver until cleared unless recovery
// - control bits 18, 19 route one of four outputs to current monitor
// - status bit 0 is NOR of fault bits 1 to 22 of both words
`timescale 1ns/1ps
`include "dcsb_defines.svh"

module dcsb_core
  import dcsb_pkg::*;
  #(
    parameter int STARTUP_CYC = (`DCSB_STARTUP_TIME_NS + `DCSB_CLK_PERIOD_NS - 1)
                                / `DCSB_CLK_PERIOD_NS,
    parameter int RETRY_CYC   = `DCSB_OC_RETRY_PERIOD_NS / `DCSB_CLK_PERIOD_NS
  )
  (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        link_clk_i,
    input  wire logic [23:0] frame_word_i,
    input  wire logic        frame_commit_i,
    input  wire logic        vs_over_i,
    input  wire logic        vs_under_i,
    input  wire logic        thermal_shutdown_i,
    input  wire logic        temp_warning_i,
    input  wire logic [2:0]  overcurrent_i,
    input  wire logic [2:0]  oc_recovery_en_i,
    input  wire logic [12:0] lower_status_i,
    input  wire logic        other_word_fault_i,
    output logic      [2:0]  hs_drive_o,
    output logic      [3:0]  cm_route_o,
    output logic      [23:0] status_word_o,
    output logic             fault_free_o,
    output logic             clear_all_status_o,
    output logic             active_mode_o
  );

  localparam int CNT_W  = 16;
  localparam int ON_LOW  = RETRY_CYC * `DCSB_DUTY_LOW_PCT / 100;
  localparam int ON_HIGH = RETRY_CYC * `DCSB_DUTY_HIGH_PCT / 100;

  // ----------------------------------------------------------------
  // link side: hold committed word, flag it with a toggle
  // ----------------------------------------------------------------
  dcsb_word_t link_hold;
  logic       link_tgl;
  dcsb_word_t next_link_hold;
  logic       next_link_tgl;

  always_comb
  begin
    next_link_hold = frame_commit_i ? frame_word_i : link_hold;
    next_link_tgl  = link_tgl ^ frame_commit_i;
  end

  always_ff @(posedge link_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      link_hold <= `DCSB_WORD_RESET;
      link_tgl  <= 1'b0;
    end
    else
    begin
      link_hold <= next_link_hold;
      link_tgl  <= next_link_tgl;
    end
  end

  // ----------------------------------------------------------------
  // synchronisers for link toggle and fault inputs
  // ----------------------------------------------------------------
  logic [7:0] sync_q;
  logic       tgl_s;
  logic       vs_over_s;
  logic       vs_under_s;
  logic       tsd_s;
  logic       tw_s;
  logic [2:0] oc_s;

  dcsb_sync3
    #(
      .WIDTH (8)
    )
    u_sync
    (
      .clk_i   (mclk_i),
      .rst_i   (rst_i),
      .async_i ({link_tgl, vs_over_i, vs_under_i, thermal_shutdown_i,
                 temp_warning_i, overcurrent_i}),
      .sync_o  (sync_q)
    );

  assign {tgl_s, vs_over_s, vs_under_s, tsd_s, tw_s, oc_s} = sync_q;

  // ----------------------------------------------------------------
  // commit decode
  // ----------------------------------------------------------------
  logic tgl_seen;
  logic commit;
  logic word_zero;
  logic reset_req;

  always_comb
  begin
    commit    = tgl_s ^ tgl_seen;
    word_zero = commit & ~link_hold[`DCSB_CW_SELECT_BIT];
    reset_req = word_zero & link_hold[`DCSB_CW_RESET_BIT];
  end

  // ----------------------------------------------------------------
  // control word zero
  // ----------------------------------------------------------------
  logic       ctl_enable;
  logic       ctl_duty;
  logic [1:0] ctl_cm;
  logic [2:0] ctl_on;
  logic       next_enable;
  logic       next_duty;
  logic [1:0] next_cm;
  logic [2:0] next_on;

  always_comb
  begin
    next_enable = ctl_enable;
    next_duty   = ctl_duty;
    next_cm     = ctl_cm;
    next_on     = ctl_on;
    if (word_zero)
    begin
      next_enable = link_hold[`DCSB_CW_ENABLE_BIT];
      next_duty   = link_hold[`DCSB_CW_DUTY_BIT];
      next_cm     = {link_hold[`DCSB_CW_CM_HI_BIT], link_hold[`DCSB_CW_CM_LO_BIT]};
      next_on     = {link_hold[`DCSB_CW_EIGHTH_BIT], link_hold[`DCSB_CW_SEVENTH_BIT],
                     link_hold[`DCSB_CW_SIXTH_BIT]};
    end
    if (!next_enable)
    begin
      next_duty = 1'b0;
      next_cm   = `DCSB_CM_FIRST;
      next_on   = 3'h0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tgl_seen   <= 1'b0;
      ctl_enable <= 1'b0;
      ctl_duty   <= 1'b0;
      ctl_cm     <= `DCSB_CM_FIRST;
      ctl_on     <= 3'h0;
    end
    else
    begin
      tgl_seen   <= tgl_s;
      ctl_enable <= next_enable;
      ctl_duty   <= next_duty;
      ctl_cm     <= next_cm;
      ctl_on     <= next_on;
    end
  end

  // ----------------------------------------------------------------
  // mode and start-up timer
  // ----------------------------------------------------------------
  dcsb_mode_e       mode;
  dcsb_mode_e       next_mode;
  logic [CNT_W-1:0] su_cnt;
  logic [CNT_W-1:0] next_su_cnt;

  always_comb
  begin
    next_mode   = mode;
    next_su_cnt = su_cnt;
    case (mode)
      DCSB_STANDBY:
      begin
        next_su_cnt = '0;
        if (ctl_enable)
        begin
          next_mode = DCSB_STARTUP;
        end
      end
      DCSB_STARTUP:
      begin
        next_su_cnt = su_cnt + CNT_W'(1);
        if (!ctl_enable)
        begin
          next_mode = DCSB_STANDBY;
        end
        else if (su_cnt == CNT_W'(STARTUP_CYC - 1))
        begin
          next_mode = DCSB_ACTIVE;
        end
      end
      DCSB_ACTIVE:
      begin
        if (!ctl_enable)
        begin
          next_mode = DCSB_STANDBY;
        end
      end
      default:
      begin
        next_mode = DCSB_STANDBY;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode   <= DCSB_STANDBY;
      su_cnt <= '0;
    end
    else
    begin
      mode   <= next_mode;
      su_cnt <= next_su_cnt;
    end
  end

  // ----------------------------------------------------------------
  // sticky fault flags, set wins over clear, standby clears
  // ----------------------------------------------------------------
  logic       vs_ov_f;
  logic       vs_uv_f;
  logic       tsd_f;
  logic       tw_f;
  logic [2:0] oc_f;
  logic       next_vs_ov_f;
  logic       next_vs_uv_f;
  logic       next_tsd_f;
  logic       next_tw_f;
  logic [2:0] next_oc_f;

  always_comb
  begin
    next_vs_ov_f = vs_over_s | (vs_ov_f & ~reset_req);
    next_vs_uv_f = vs_under_s | (vs_uv_f & ~reset_req);
    next_tsd_f   = tsd_s | (tsd_f & ~reset_req);
    next_tw_f    = tw_s | (tw_f & ~reset_req);
    next_oc_f    = oc_s | (oc_f & {3{~reset_req}});
    if (!ctl_enable)
    begin
      next_vs_ov_f = 1'b0;
      next_vs_uv_f = 1'b0;
      next_tsd_f   = 1'b0;
      next_tw_f    = 1'b0;
      next_oc_f    = 3'h0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      vs_ov_f <= 1'b0;
      vs_uv_f <= 1'b0;
      tsd_f   <= 1'b0;
      tw_f    <= 1'b0;
      oc_f    <= 3'h0;
    end
    else
    begin
      vs_ov_f <= next_vs_ov_f;
      vs_uv_f <= next_vs_uv_f;
      tsd_f   <= next_tsd_f;
      tw_f    <= next_tw_f;
      oc_f    <= next_oc_f;
    end
  end

  // ----------------------------------------------------------------
  // over-current retry timing
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] rt_cnt;
  logic [CNT_W-1:0] next_rt_cnt;
  logic             retry_on;

  always_comb
  begin
    next_rt_cnt = (rt_cnt == CNT_W'(RETRY_CYC - 1)) ? '0 : rt_cnt + CNT_W'(1);
    retry_on    = ctl_duty ? (rt_cnt < CNT_W'(ON_HIGH))
                           : (rt_cnt < CNT_W'(ON_LOW));
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rt_cnt <= '0;
    end
    else
    begin
      rt_cnt <= next_rt_cnt;
    end
  end

  // ----------------------------------------------------------------
  // drivers, monitor route and status word
  // ----------------------------------------------------------------
  logic       gate;
  logic [2:0] next_drive;
  logic [3:0] next_route;
  logic [21:0] fault_bits;
  dcsb_word_t next_status;

  always_comb
  begin
    // supply fault only blocks while present, thermal flag blocks until cleared
    gate = (mode == DCSB_ACTIVE) & ~tsd_f
           & ~vs_over_s & ~vs_under_s;
    for (int i = 0; i < 3; i++)
    begin
      next_drive[i] = ctl_on[i] & gate
                      & (~oc_f[i] | (oc_recovery_en_i[i] & retry_on));
    end
    case (ctl_cm)
      `DCSB_CM_FIRST:  next_route = 4'h1;
      `DCSB_CM_FOURTH: next_route = 4'h2;
      `DCSB_CM_FIFTH:  next_route = 4'h4;
      `DCSB_CM_EIGHTH: next_route = 4'h8;
      default:         next_route = 4'h1;
    endcase
    next_status = `DCSB_WORD_RESET;
    next_status[`DCSB_SW_ALWAYS_ONE_BIT] = 1'b1;
    next_status[`DCSB_SW_VS_OVER_BIT]    = vs_ov_f;
    next_status[`DCSB_SW_VS_UNDER_BIT]   = vs_uv_f;
    next_status[`DCSB_SW_THERMAL_BIT]    = tsd_f;
    next_status[`DCSB_SW_TEMP_WARN_BIT]  = tw_f;
    next_status[`DCSB_SW_NOT_READY_BIT]  = (mode == DCSB_STARTUP);
    next_status[`DCSB_SW_OC_EIGHTH_BIT]  = oc_f[2];
    next_status[`DCSB_SW_ZERO_BIT]       = 1'b0;
    next_status[`DCSB_SW_OC_SEVENTH_BIT] = oc_f[1];
    next_status[`DCSB_SW_OC_SIXTH_BIT]   = oc_f[0];
    next_status[`DCSB_SW_LOWER_HI_BIT:`DCSB_SW_LOWER_LO_BIT] = lower_status_i;
    fault_bits = next_status[`DCSB_SW_VS_OVER_BIT:`DCSB_SW_LOWER_LO_BIT];
    next_status[`DCSB_SW_NO_FAULT_BIT]   = ~(|fault_bits | other_word_fault_i);
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hs_drive_o         <= 3'h0;
      cm_route_o         <= 4'h1;
      status_word_o      <= `DCSB_WORD_RESET;
      fault_free_o       <= 1'b0;
      clear_all_status_o <= 1'b0;
      active_mode_o      <= 1'b0;
    end
    else
    begin
      hs_drive_o         <= next_drive;
      cm_route_o         <= next_route;
      status_word_o      <= next_status;
      fault_free_o       <= next_status[`DCSB_SW_NO_FAULT_BIT];
      clear_all_status_o <= reset_req;
      active_mode_o      <= (mode == DCSB_ACTIVE);
    end
  end

endmodule

//--- verilog/dcsb_defines.svh
`ifndef DCSB_DEFINES_SVH
`define DCSB_DEFINES_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define DCSB_CLK_PERIOD_NS       20
`define DCSB_STARTUP_TIME_NS     100000
`define DCSB_OC_RETRY_PERIOD_NS  160000
`define DCSB_DUTY_LOW_PCT        12
`define DCSB_DUTY_HIGH_PCT       25

// ----------------------------------------------------------------
// control word zero fields
// ----------------------------------------------------------------
`define DCSB_CW_SELECT_BIT       0
`define DCSB_CW_SIXTH_BIT        14
`define DCSB_CW_SEVENTH_BIT      15
`define DCSB_CW_EIGHTH_BIT       17
`define DCSB_CW_CM_LO_BIT        18
`define DCSB_CW_CM_HI_BIT        19
`define DCSB_CW_DUTY_BIT         21
`define DCSB_CW_RESET_BIT        22
`define DCSB_CW_ENABLE_BIT       23

// ----------------------------------------------------------------
// status word zero fields
// ----------------------------------------------------------------
`define DCSB_SW_NO_FAULT_BIT     0
`define DCSB_SW_LOWER_LO_BIT     1
`define DCSB_SW_LOWER_HI_BIT     13
`define DCSB_SW_OC_SIXTH_BIT     14
`define DCSB_SW_OC_SEVENTH_BIT   15
`define DCSB_SW_ZERO_BIT         16
`define DCSB_SW_OC_EIGHTH_BIT    17
`define DCSB_SW_NOT_READY_BIT    18
`define DCSB_SW_TEMP_WARN_BIT    19
`define DCSB_SW_THERMAL_BIT      20
`define DCSB_SW_VS_UNDER_BIT     21
`define DCSB_SW_VS_OVER_BIT      22
`define DCSB_SW_ALWAYS_ONE_BIT   23

// ----------------------------------------------------------------
// current monitor select codes and reset values
// ----------------------------------------------------------------
`define DCSB_CM_FIRST            2'h0
`define DCSB_CM_FOURTH           2'h1
`define DCSB_CM_FIFTH            2'h2
`define DCSB_CM_EIGHTH           2'h3
`define DCSB_WORD_RESET          24'h000000

`endif

//--- verilog/dcsb_pkg.sv
package dcsb_pkg;

  // ----------------------------------------------------------------
  // operating mode
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    DCSB_STANDBY = 3'h1,
    DCSB_STARTUP = 3'h2,
    DCSB_ACTIVE  = 3'h4
  } dcsb_mode_e;

  typedef logic [23:0] dcsb_word_t;

endpackage

//--- verilog/dcsb_sync3.sv
`timescale 1ns/1ps

// three-stage synchroniser, a change is taken once stages two and three agree
module dcsb_sync3
  #(
    parameter int WIDTH = 1
  )
  (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
  );

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_sync;

  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      next_sync[i] = (stage2[i] == stage3[i]) ? stage3[i] : sync_o[i];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      sync_o <= '0;
    end
    else
    begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
      sync_o <= next_sync;
    end
  end

endmodule
